// ### verilog/breakpoint_trace_debug.sv
// Purpose: breakpoint comparators, instruction tagging and trace buffer
// Assumes: core bus and tag strobes synchronous to clock; APB3 slave
// Notes: answers an access phase after one wait cycle
//
// Summary of operation
// (R1) upper tag pin low tags upper word
// (R2) lower tag pin low tags lower word
// (R3) while armed only enable, arm and interrupt clear writable
// (R4) trace word read as two bytes
// (R5) count register: full flag, zero, count
// (R6) comparators hold extended, high, low bytes
// (R7) control two holds breakpoint and direction bits
// (R8) control three holds masks and direction bits
// (R9) comparator C is third legacy breakpoint
// (R10) external cycles observed via external bus interface
// (R11) same registers serve legacy and trace modes
// (R12) arm without enable writes zero to both
// (R13) capture field selects normal, loop, detail, profile
// (R14) reserved bits read zero, ignore writes
`timescale 1ns/100ps
module breakpoint_trace_debug
  import debug_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core bus and external bus interface observations
  input wire debug_pkg::bus_cycle_type internal_bus,
  input wire debug_pkg::bus_cycle_type external_bus_interface,
  // tag pins and instruction queue
  input wire debug_pkg::tag_pins_type tag_pins,
  // breakpoint requests and interrupt
  output debug_pkg::break_out_type break_out,
  output logic interrupt
);
  import debug_pkg::*;

  // ==========================================================
  // registers
  logic [7:0] control_1, status_control, comp_c_ext, comp_c_high, comp_c_low;
  logic [7:0] control_2, control_3, comp_a_ext, comp_a_high, comp_a_low;
  logic [7:0] comp_b_ext, comp_b_high, comp_b_low;
  logic [3:0] int_status, int_enable;
  logic [15:0] trace_mem [TRACE_DEPTH];
  logic [TRACE_AW-1:0] write_ptr, read_ptr;
  logic [TRACE_AW:0] entry_count;
  logic [15:0] last_stored;
  logic [15:0] last_instruction;
  logic loop_primed;

  // ==========================================================
  // register access decode
  wire [5:0] reg_index = paddr[7:2];
  wire access_edge = psel & penable & pready;
  wire aligned = (paddr[1:0] == 2'b00);
  // unaligned or unmapped addresses answer with pslverr
  wire mapped = aligned & (reg_index >= IDX_CONTROL_1) & (reg_index <= IDX_INT_ENABLE);
  wire wr_edge = access_edge & pwrite & mapped;
  wire rd_edge = access_edge & ~pwrite & mapped;
  wire [7:0] wbyte = pwdata[7:0];
  wire armed = control_1[C1_ARM];
  // trace mode and legacy mode share one register set (R11)
  wire legacy_mode = control_2[C2_AB_BRK_EN];
  wire trace_mode = control_1[C1_ENABLE];
  wire cfg_write = wr_edge & ~armed; // R3
  wire wr_c1 = wr_edge & (reg_index == IDX_CONTROL_1);
  wire wr_sc = cfg_write & (reg_index == IDX_STATUS_CONTROL);
  wire rd_low = rd_edge & (reg_index == IDX_TRACE_LOW);
  // arm without enable is taken as zero for both bits (R12)
  wire [1:0] arm_bits = (wbyte[C1_ENABLE] | ~wbyte[C1_ARM]) ?
                        wbyte[C1_ENABLE:C1_ARM] : 2'b00;
  wire arm_written = wr_c1 & arm_bits[0];
  wire [7:0] next_control_1_cfg = {arm_bits, wbyte[5:0] & C1_WRITE_MASK[5:0]}; // R14
  wire [7:0] next_control_1_arm = {arm_bits, control_1[5:0]}; // R3
  wire capture_type capture_mode = capture_type'(control_1[1:0]);

  // ==========================================================
  // bus observation: external cycles come through the bus interface (R10)
  wire bus_cycle_type observed = internal_bus.external ? external_bus_interface : internal_bus;

  // comparator hit: high and low bytes against the address, extended bits [5:0] against the page; [7:6] unused
  wire a_addr_hit = (observed.addr == {comp_a_high, comp_a_low})
                    & (observed.page == comp_a_ext[5:0]); // R6
  wire b_addr_hit = (observed.addr == {comp_b_high, comp_b_low})
                    & (observed.page == comp_b_ext[5:0]); // R6
  wire c_addr_hit = (observed.addr == {comp_c_high, comp_c_low})
                    & (observed.page == comp_c_ext[5:0]); // R6
  // in full mode comparator B holds data, byte masks drop lanes (R8)
  wire b_data_hi = control_3[C3_B_MASK_HI] | (observed.data[15:8] == comp_b_high);
  wire b_data_lo = control_3[C3_B_MASK_LO] | (observed.data[7:0] == comp_b_low);
  wire a_dir_ok = ~control_3[C3_A_DIR_EN] | (observed.read == control_3[C3_A_DIR]); // R8
  wire b_dir_ok = ~control_3[C3_B_DIR_EN] | (observed.read == control_3[C3_B_DIR]); // R8
  wire c_dir_ok = ~control_2[C2_C_DIR_EN] | (observed.read == control_2[C2_C_DIR]); // R7
  wire a_match = observed.valid & a_addr_hit & a_dir_ok;
  wire b_match = observed.valid & b_dir_ok &
                 (control_2[C2_FULL] ? (a_addr_hit & b_data_hi & b_data_lo) : b_addr_hit);
  wire full_match = a_match & b_match;
  wire ab_match = control_2[C2_FULL] ? full_match : (a_match | b_match); // R7
  // C serves as a breakpoint unless trace is enabled in loop capture mode
  wire c_match = observed.valid & c_addr_hit & c_dir_ok; // R9
  wire c_as_break = control_2[C2_C_BRK_EN] & ~(trace_mode & capture_mode == CAP_LOOP); // R9
  wire ab_break = legacy_mode & ab_match; // R7
  wire c_break = c_as_break & c_match; // R9

  // ==========================================================
  // instruction tagging on the falling bus clock strobe
  // e_falling must last one clock or a word is tagged twice
  wire tag_strobe = tag_pins.e_falling & tag_pins.queue_load & tag_pins.tagging_on;
  wire tag_up = tag_strobe & ~tag_pins.upper_word_tag_pin; // R1
  wire tag_low = tag_strobe & ~tag_pins.lower_word_tag_pin & tag_pins.low_byte_strobe
                 & (tag_pins.expanded_wide | tag_pins.emulation_narrow); // R2
  wire tag_any = tag_up | tag_low;

  // ==========================================================
  // trace capture
  wire is_cof = observed.change_of_flow & observed.program_fetch;
  wire want_normal = (capture_mode == CAP_NORMAL) & is_cof; // R13
  // nothing stored since arming, so no fetch is a repeat yet
  wire want_loop = (capture_mode == CAP_LOOP) & is_cof &
                   (~loop_primed | (observed.addr != last_stored)); // R13
  wire want_detail = (capture_mode == CAP_DETAIL) & ~observed.program_fetch; // R13
  wire full_flag = entry_count[TRACE_AW];
  wire store = armed & trace_mode & observed.valid & ~full_flag &
               (want_normal | want_loop | want_detail);
  wire [15:0] store_word = (capture_mode == CAP_DETAIL) ? observed.data : observed.addr;
  wire instr_done = observed.valid & observed.program_fetch;
  // profile mode returns the last executed instruction address (R13)
  wire [15:0] trace_word = (capture_mode == CAP_PROFILE) ? last_instruction
                                                          : trace_mem[read_ptr];

  // ==========================================================
  // interrupt events: A hit, B hit, C hit, buffer filled
  wire filling = store & (entry_count == 7'(TRACE_DEPTH - 1));
  wire [3:0] events = {filling, c_match & armed, b_match & armed, a_match & armed};
  wire int_clear_wr = wr_edge & (reg_index == IDX_INT_CLEAR);
  wire [3:0] clear_bits = int_clear_wr ? (wbyte[3:0] & INT_MASK) : 4'h0;
  wire [3:0] next_int_status = (int_status & ~clear_bits) | events;
  // match flags: cleared by arming or by a write here, a hit in that cycle wins
  wire flag_clear = arm_written | wr_sc;
  wire [2:0] flags_kept = flag_clear ? 3'b000 : status_control[7:5];
  wire [2:0] next_flags = flags_kept | {c_match & armed, b_match & armed, a_match & armed};
  wire [3:0] next_sc_low = wr_sc ? (wbyte[3:0] & SC_WRITE_MASK[3:0]) : status_control[3:0];

  // ==========================================================
  // read data selection; reserved bits and unused positions read zero (R14)
  logic [7:0] read_byte;
  always_comb
  begin
    case (reg_index)
      IDX_CONTROL_1: read_byte = control_1;
      IDX_STATUS_CONTROL: read_byte = status_control;
      IDX_TRACE_HIGH: read_byte = trace_word[15:8]; // R4
      IDX_TRACE_LOW: read_byte = trace_word[7:0]; // R4
      IDX_ENTRY_COUNT: read_byte = {full_flag, 1'b0, entry_count[5:0]}; // R5
      IDX_COMP_C_EXT: read_byte = comp_c_ext;
      IDX_COMP_C_HIGH: read_byte = comp_c_high;
      IDX_COMP_C_LOW: read_byte = comp_c_low;
      IDX_CONTROL_2: read_byte = control_2;
      IDX_CONTROL_3: read_byte = control_3;
      IDX_COMP_A_EXT: read_byte = comp_a_ext;
      IDX_COMP_A_HIGH: read_byte = comp_a_high;
      IDX_COMP_A_LOW: read_byte = comp_a_low;
      IDX_COMP_B_EXT: read_byte = comp_b_ext;
      IDX_COMP_B_HIGH: read_byte = comp_b_high;
      IDX_COMP_B_LOW: read_byte = comp_b_low;
      IDX_INT_STATUS: read_byte = {4'h0, int_status};
      IDX_INT_ENABLE: read_byte = {4'h0, int_enable};
      default: read_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // apb answer: one wait cycle keeps prdata a registered output
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= (psel & penable & ~pready & mapped & ~pwrite) ? {24'h00_0000, read_byte}
                                                             : 32'h0000_0000;
    end
  end

  // ==========================================================
  // control register 1 and status; arming ends when the buffer fills
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      control_1 <= REG_RESET;
      status_control <= REG_RESET;
    end
    else
    begin
      if (wr_c1)
        control_1 <= armed ? next_control_1_arm : next_control_1_cfg; // R3 R12
      // a full buffer disarms even against a write that cycle
      if (filling)
        control_1[C1_ARM] <= 1'b0;
      status_control <= {next_flags, 1'b0, next_sc_low}; // R14
    end
  end

  // ==========================================================
  // configuration registers, locked while armed (R3)
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      comp_c_ext <= REG_RESET;
      comp_c_high <= REG_RESET;
      comp_c_low <= REG_RESET;
      control_2 <= REG_RESET;
      control_3 <= REG_RESET;
      comp_a_ext <= REG_RESET;
      comp_a_high <= REG_RESET;
      comp_a_low <= REG_RESET;
      comp_b_ext <= REG_RESET;
      comp_b_high <= REG_RESET;
      comp_b_low <= REG_RESET;
      int_enable <= 4'h0;
    end
    else if (cfg_write)
    begin
      case (reg_index)
        IDX_COMP_C_EXT: comp_c_ext <= wbyte; // R6
        IDX_COMP_C_HIGH: comp_c_high <= wbyte; // R6
        IDX_COMP_C_LOW: comp_c_low <= wbyte; // R6
        IDX_CONTROL_2: control_2 <= wbyte; // R7
        IDX_CONTROL_3: control_3 <= wbyte; // R8
        IDX_COMP_A_EXT: comp_a_ext <= wbyte; // R6
        IDX_COMP_A_HIGH: comp_a_high <= wbyte; // R6
        IDX_COMP_A_LOW: comp_a_low <= wbyte; // R6
        IDX_COMP_B_EXT: comp_b_ext <= wbyte; // R6
        IDX_COMP_B_HIGH: comp_b_high <= wbyte; // R6
        IDX_COMP_B_LOW: comp_b_low <= wbyte; // R6
        IDX_INT_ENABLE: int_enable <= wbyte[3:0];
        default: int_enable <= int_enable;
      endcase
    end
  end

  // ==========================================================
  // trace buffer; arming restarts it
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      write_ptr <= '0;
      read_ptr <= '0;
      entry_count <= '0;
      last_stored <= 16'h0000;
      last_instruction <= 16'h0000;
      loop_primed <= 1'b0;
    end
    else
    begin
      if (arm_written & ~armed)
      begin
        write_ptr <= '0;
        read_ptr <= '0;
        entry_count <= '0;
        loop_primed <= 1'b0;
      end
      else
      begin
        if (store)
        begin
          write_ptr <= write_ptr + 1'b1;
          entry_count <= entry_count + 1'b1;
          last_stored <= observed.addr;
          loop_primed <= 1'b1;
        end
        // outside profile mode the low byte read advances to the next word (R4)
        // reads past the count are not refused and return stale words
        if (rd_low & (capture_mode != CAP_PROFILE))
          read_ptr <= read_ptr + 1'b1;
      end
      if (instr_done)
        last_instruction <= observed.addr;
    end
  end

  // memory holds no reset so it can map onto plain storage
  always_ff @(posedge clock)
  begin
    if (store)
      trace_mem[write_ptr] <= store_word;
  end

  // ==========================================================
  // interrupt status, enable and output
  // an enable write reaches the output one cycle after the access
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      int_status <= 4'h0;
      interrupt <= 1'b0;
    end
    else
    begin
      int_status <= next_int_status;
      interrupt <= |(next_int_status & int_enable);
    end
  end

  // ==========================================================
  // breakpoint and tag outputs
  // halt select copies the control bit one cycle late
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      break_out <= '0;
    else
    begin
      break_out.tag_upper <= tag_up; // R1
      break_out.tag_lower <= tag_low; // R2
      // tag select picks a tagged break at a tagged word, else forced
      break_out.tagged_break <= tag_any & ((ab_break & control_2[C2_AB_TAG]) |
                                           (c_break & control_2[C2_C_TAG])); // R7 R9
      break_out.forced_break <= (ab_break & ~control_2[C2_AB_TAG]) |
                                (c_break & ~control_2[C2_C_TAG]); // R7 R9
      break_out.halt_select <= control_2[C2_HALT_SEL]; // R7
    end
  end
endmodule

// ### verilog/debug_pkg.sv
// Purpose: constants and types for the breakpoint and trace debug block
// Assumes: APB register access, 8-bit registers in the low byte of each word
// Notes: byte address of a register is four times its index
package debug_pkg;
  // ==========================================================
  // register indices
  localparam logic [5:0] IDX_CONTROL_1 = 6'h20;
  localparam logic [5:0] IDX_STATUS_CONTROL = 6'h21;
  localparam logic [5:0] IDX_TRACE_HIGH = 6'h22;
  localparam logic [5:0] IDX_TRACE_LOW = 6'h23;
  localparam logic [5:0] IDX_ENTRY_COUNT = 6'h24;
  localparam logic [5:0] IDX_COMP_C_EXT = 6'h25;
  localparam logic [5:0] IDX_COMP_C_HIGH = 6'h26;
  localparam logic [5:0] IDX_COMP_C_LOW = 6'h27;
  localparam logic [5:0] IDX_CONTROL_2 = 6'h28;
  localparam logic [5:0] IDX_CONTROL_3 = 6'h29;
  localparam logic [5:0] IDX_COMP_A_EXT = 6'h2A;
  localparam logic [5:0] IDX_COMP_A_HIGH = 6'h2B;
  localparam logic [5:0] IDX_COMP_A_LOW = 6'h2C;
  localparam logic [5:0] IDX_COMP_B_EXT = 6'h2D;
  localparam logic [5:0] IDX_COMP_B_HIGH = 6'h2E;
  localparam logic [5:0] IDX_COMP_B_LOW = 6'h2F;
  localparam logic [5:0] IDX_INT_STATUS = 6'h30;
  localparam logic [5:0] IDX_INT_CLEAR = 6'h31;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h32;
  // ==========================================================
  // field positions
  localparam int C1_ENABLE = 7;
  localparam int C1_ARM = 6;
  localparam logic [7:0] C1_WRITE_MASK = 8'hFB;
  localparam int C2_AB_BRK_EN = 7;
  localparam int C2_FULL = 6;
  localparam int C2_HALT_SEL = 5;
  localparam int C2_AB_TAG = 4;
  localparam int C2_C_BRK_EN = 3;
  localparam int C2_C_TAG = 2;
  localparam int C2_C_DIR_EN = 1;
  localparam int C2_C_DIR = 0;
  localparam int C3_A_MASK_HI = 7;
  localparam int C3_A_MASK_LO = 6;
  localparam int C3_B_MASK_HI = 5;
  localparam int C3_B_MASK_LO = 4;
  localparam int C3_A_DIR_EN = 3;
  localparam int C3_A_DIR = 2;
  localparam int C3_B_DIR_EN = 1;
  localparam int C3_B_DIR = 0;
  localparam logic [7:0] SC_WRITE_MASK = 8'h0F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] INT_MASK = 4'hF;
  // ==========================================================
  // trace buffer geometry
  localparam int TRACE_DEPTH = 64;
  localparam int TRACE_AW = 6;
  // ==========================================================
  typedef enum logic [1:0] {CAP_NORMAL, CAP_LOOP, CAP_DETAIL, CAP_PROFILE} capture_type;

  typedef struct packed {
    logic valid;
    logic read;
    logic external;
    logic change_of_flow;
    logic program_fetch;
    logic [5:0] page;
    logic [15:0] addr;
    logic [15:0] data;
  } bus_cycle_type;

  typedef struct packed {
    logic tagging_on;
    logic expanded_wide;
    logic emulation_narrow;
    logic low_byte_strobe;
    logic upper_word_tag_pin;
    logic lower_word_tag_pin;
    logic e_falling;
    logic queue_load;
  } tag_pins_type;

  typedef struct packed {
    logic tag_upper;
    logic tag_lower;
    logic tagged_break;
    logic forced_break;
    logic halt_select;
  } break_out_type;
endpackage

// ### verification/breakpoint_trace_debug_asserts.sv
// Purpose: concurrent checks on the debug block ports
// Assumes: one clock domain, reset asynchronous and active high
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module breakpoint_trace_debug_asserts
  import debug_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire debug_pkg::bus_cycle_type internal_bus,
  input wire debug_pkg::bus_cycle_type external_bus_interface,
  input wire debug_pkg::tag_pins_type tag_pins,
  input wire debug_pkg::break_out_type break_out,
  input wire logic interrupt
);
  // ==========================================================
  // decoded conditions
  wire logic [5:0] idx = paddr[7:2];
  wire logic strobe = tag_pins.e_falling && tag_pins.queue_load && tag_pins.tagging_on;
  wire logic lane_ok = tag_pins.low_byte_strobe && (tag_pins.expanded_wide || tag_pins.emulation_narrow);
  wire logic wr_c2 = psel && penable && pready && pwrite && idx == IDX_CONTROL_2;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // assertions
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_phase:
    assert property (pready |-> psel && penable && $past(psel)) else $error("pready off phase");
  a_rdata_idle:
    assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  a_rdata_byte:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_count_zero:
    assert property (pready && !pwrite && idx == IDX_ENTRY_COUNT |-> !prdata[6])
      else $error("count bit 6 set");
  a_map_clean:
    assert property (pready && paddr[1:0] == 2'b00 && idx >= 6'h20 && idx <= 6'h2F |-> !pslverr)
      else $error("error on mapped register");
  a_tag_upper:
    assert property (strobe && !tag_pins.upper_word_tag_pin |=> break_out.tag_upper)
      else $error("upper tag missing");
  a_tag_lower:
    assert property (strobe && lane_ok && !tag_pins.lower_word_tag_pin |=> break_out.tag_lower)
      else $error("lower tag missing");
  a_lower_lane:
    assert property (!lane_ok |=> !break_out.tag_lower) else $error("lower tag without lane");
  a_halt_write:
    assert property ($changed(break_out.halt_select) |-> $past(wr_c2) || $past(wr_c2, 2))
      else $error("halt select moved without write");
endmodule

bind breakpoint_trace_debug breakpoint_trace_debug_asserts chk_u (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .internal_bus(internal_bus), .external_bus_interface(external_bus_interface),
  .tag_pins(tag_pins), .break_out(break_out), .interrupt(interrupt)
);

// ### verification/core_bus_model.sv
// Purpose: core bus and tag pin driver facing the debug block
// Assumes: one bus cycle is valid for one clock
// Notes: tasks are called from the bench
`timescale 1ns/100ps
module core_bus_model
  import debug_pkg::*;
(
  // clock
  input wire logic clock,
  // observations and tag pins
  output debug_pkg::bus_cycle_type internal_bus,
  output debug_pkg::bus_cycle_type external_bus_interface,
  output debug_pkg::tag_pins_type tag_pins
);
  initial
  begin
    internal_bus = '0;
    external_bus_interface = '0;
    tag_pins = 8'h0C;
  end
  // external cycles leave inverted address and data on the internal view
  task automatic cycle(input logic [15:0] a, input logic [15:0] d, input logic pf, cof, ext);
    @(posedge clock);
    internal_bus <= '{1'b1, 1'b1, ext, cof, pf, 6'h00, ext ? ~a : a, ext ? ~d : d};
    external_bus_interface <= '{ext, 1'b1, ext, cof, pf, 6'h00, a, d};
    @(posedge clock);
    internal_bus <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 6'h00, ~a, ~d};
    external_bus_interface <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 6'h00, ~a, ~d};
  endtask
  // pins held only while the falling-edge strobe stands, then pulled up
  task automatic tag(input logic [3:0] m, input logic up_n, lo_n);
    @(posedge clock);
    tag_pins <= {m, up_n, lo_n, 2'b11};
    @(posedge clock);
    tag_pins <= {m, 4'b1100};
  endtask
endmodule

// ### verification/breakpoint_trace_debug_tb_top.sv
// Purpose: self-checking bench for the debug block
// Assumes: apb answers whenever pready rises
// Notes: random data from a fixed seed
`timescale 1ns/100ps
module breakpoint_trace_debug_tb_top;
  import debug_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic interrupt;
  bus_cycle_type internal_bus;
  bus_cycle_type external_bus_interface;
  tag_pins_type tag_pins;
  break_out_type break_out;
  logic [31:0] rd;
  logic err;
  logic [7:0] d;
  logic [15:0] a;
  logic [15:0] v;
  logic [3:0] tm;
  logic up;
  logic lo;
  logic [15:0] exp_q[$];
  logic [15:0] atab[6] = '{16'h2000, 16'h2000, 16'h2010, 16'h2020, 16'h2020, 16'h2030};
  logic [7:0] cfg[11] = '{8'h00, 8'h56, 8'h78, 8'h88, 8'h00, 8'h00, 8'h12, 8'h34, 8'h00,
    8'hFF, 8'hFE};
  int n_mismatch = 0;
  int cmp_count = 0;
  always #25 clock = ~clock;
  breakpoint_trace_debug dut_u (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_bus(internal_bus), .external_bus_interface(external_bus_interface),
    .tag_pins(tag_pins), .break_out(break_out), .interrupt(interrupt));
  core_bus_model bus_u (.clock(clock), .internal_bus(internal_bus),
    .external_bus_interface(external_bus_interface), .tag_pins(tag_pins));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] val);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, val};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [7:0] rw_exp(logic [5:0] i, logic [7:0] x);
    if (i == IDX_CONTROL_1) return x & C1_WRITE_MASK;
    if (i == IDX_STATUS_CONTROL || i == IDX_INT_ENABLE) return x & 8'h0F;
    if (i == IDX_ENTRY_COUNT || i == IDX_INT_STATUS) return 8'h00;
    return x;
  endfunction
  function automatic logic [1:0] exp_tag(logic [3:0] m, logic un, logic ln);
    exp_tag[1] = m[3] && !un;
    exp_tag[0] = m[3] && !ln && m[0] && (m[2] || m[1]);
  endfunction
  // ==========================================================
  // watchdog: whole run is about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    conclude();
  end
  // ==========================================================
  // tests
  initial
  begin
    void'($urandom(32'h67162D8D));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (int i = 6'h20; i <= 6'h32; i++)
      if (i != 6'h31 && i != 6'h22 && i != 6'h23) rdchk(6'(i), 8'h00);
    apb(1'b0, 6'h3F, 8'h00);
    chk({31'h0, err}, 32'h1);
    done("reset");
    repeat (4)
      for (int i = 6'h20; i <= 6'h32; i++)
        if (i != 6'h31 && i != 6'h22 && i != 6'h23)
        begin
          d = 8'($urandom) & (i == 6'h20 ? 8'h3F : 8'hFF);
          apb(1'b1, 6'(i), d);
          rdchk(6'(i), rw_exp(6'(i), d));
        end
    done("readback");
    apb(1'b1, IDX_COMP_A_HIGH, 8'h12);
    apb(1'b1, IDX_CONTROL_1, 8'h40);
    rdchk(IDX_CONTROL_1, 8'h00);
    apb(1'b1, IDX_CONTROL_1, 8'hC0);
    apb(1'b1, IDX_COMP_A_HIGH, 8'hEE);
    rdchk(IDX_COMP_A_HIGH, 8'h12);
    apb(1'b1, IDX_CONTROL_1, 8'hC3);
    rdchk(IDX_CONTROL_1, 8'hC0);
    apb(1'b1, IDX_CONTROL_1, 8'h00);
    done("arm");
    for (int i = 0; i < 11; i++) apb(1'b1, 6'(6'h25 + i), cfg[i]);
    apb(1'b1, IDX_STATUS_CONTROL, 8'h00);
    apb(1'b1, IDX_CONTROL_1, 8'hC0);
    bus_u.cycle(16'h1234, 16'($urandom), 1'b1, 1'b0, 1'b0);
    bus_u.cycle(16'h5678, 16'($urandom), 1'b1, 1'b0, 1'b0);
    rdchk(IDX_INT_STATUS, 8'h05);
    rdchk(IDX_STATUS_CONTROL, 8'hA0);
    apb(1'b1, IDX_CONTROL_1, 8'h00);
    apb(1'b1, IDX_CONTROL_2, 8'h00);
    apb(1'b1, IDX_INT_CLEAR, 8'h0F);
    rdchk(IDX_INT_STATUS, 8'h00);
    done("hits");
    for (int m = 0; m < 4; m++)
    begin
      exp_q.delete();
      apb(1'b1, IDX_CONTROL_1, 8'hC0 | 8'(m));
      for (int k = 0; k < 8; k++)
      begin
        a = k < 6 ? atab[k] : 16'h3000;
        v = 16'($urandom);
        bus_u.cycle(a, v, k < 6, k < 6, k == 2);
        if (m == 0 && k < 6) exp_q.push_back(a);
        if (m == 1 && k < 6 && (exp_q.size() == 0 || exp_q[$] != a)) exp_q.push_back(a);
        if (m == 2 && k >= 6) exp_q.push_back(v);
      end
      rdchk(IDX_ENTRY_COUNT, 8'(exp_q.size()));
      if (m == 3) exp_q.push_back(atab[5]);
      foreach (exp_q[j])
      begin
        rdchk(IDX_TRACE_HIGH, exp_q[j][15:8]);
        rdchk(IDX_TRACE_LOW, exp_q[j][7:0]);
      end
      apb(1'b1, IDX_CONTROL_1, 8'h00);
    end
    done("capture");
    apb(1'b1, IDX_INT_ENABLE, 8'h00);
    apb(1'b1, IDX_CONTROL_1, 8'hC0);
    for (int k = 0; k < TRACE_DEPTH; k++) bus_u.cycle(16'h4000 + 16'(2 * k), 16'h0, 1'b1, 1'b1, 1'b0);
    rdchk(IDX_ENTRY_COUNT, 8'h80);
    rdchk(IDX_CONTROL_1, 8'h80);
    rdchk(IDX_INT_STATUS, 8'h08);
    chk({31'h0, interrupt}, 32'h0);
    apb(1'b1, IDX_INT_ENABLE, 8'h08);
    @(posedge clock);
    #1;
    chk({31'h0, interrupt}, 32'h1);
    apb(1'b1, IDX_INT_CLEAR, 8'h08);
    @(posedge clock);
    #1;
    chk({31'h0, interrupt}, 32'h0);
    done("full");
    apb(1'b1, IDX_CONTROL_2, 8'hA8);
    bus_u.cycle(16'h5678, 16'h0, 1'b1, 1'b0, 1'b0);
    #1;
    chk({30'h0, break_out.forced_break, break_out.halt_select}, 32'h3);
    apb(1'b1, IDX_CONTROL_2, 8'h90);
    fork
      bus_u.cycle(16'h1234, 16'h0, 1'b1, 1'b0, 1'b0);
      bus_u.tag(4'h8, 1'b0, 1'b1);
    join
    #1;
    chk({30'h0, break_out.tagged_break, break_out.forced_break}, 32'h2);
    done("breaks");
    for (int k = 0; k < 24; k++)
    begin
      tm = 4'($urandom);
      up = 1'($urandom);
      lo = 1'($urandom);
      bus_u.tag(tm, up, lo);
      #1;
      chk({30'h0, break_out.tag_upper, break_out.tag_lower}, {30'h0, exp_tag(tm, up, lo)});
    end
    done("tags");
    conclude();
  end
endmodule
